/* hw/gpm_consts.vh */
`ifndef GPM_CONSTS_VH
`define GPM_CONSTS_VH

// Core clock rate in hertz.
`define GPM_CLK_HZ          10000000
// Shortest bus-low time before sleep, in milliseconds (window is 1500 to 2200).
`define GPM_TIMEOUT_MS      1500
`define GPM_TIMEOUT_CYC     (`GPM_TIMEOUT_MS * (`GPM_CLK_HZ / 1000))
// Conversion cycle period, in milliseconds.
`define GPM_CONV_MS         880
`define GPM_CONV_CYC        (`GPM_CONV_MS * (`GPM_CLK_HZ / 1000))
// Every 1024th conversion measures converter offset.
`define GPM_OFS_EVERY       1024
`define GPM_OFS_CNT_W       10
// Result field positions inside the 16-bit result words.
`define GPM_VOLT_SHIFT      3
`define GPM_AUX_PAD         4
`define GPM_TEMP_PAD        5
// Saturation codes.
`define GPM_POS_MAX         16'h7fff
`define GPM_NEG_MIN         16'h8000
`define GPM_VOLT_MAX_RAW    13'h0fff
// Reset values.
`define GPM_RES_RST         16'h0000
`define GPM_ACC_RST         32'h0000_0000
`define GPM_SCALE_RST       8'h00

`endif

/* hw/gpm_tick.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"

module gpm_tick #(
  parameter integer PERIOD = `GPM_CONV_CYC
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        enable,
  output reg         tick_q
);

  reg [31:0] cnt_q;

  // Divider for the conversion period; it holds at zero while disabled so a
  // return to Active starts a full period rather than a partial one.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (!enable) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (cnt_q == PERIOD - 1) begin
      cnt_q  <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* hw/gpm_sleep_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"

module gpm_sleep_ctrl #(
  parameter integer TIMEOUT = `GPM_TIMEOUT_CYC
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        scl_pin,
  input  wire        sda_pin,
  input  wire        sleep_enable,
  output reg         active_q
);

  reg        scl_m_q;
  reg        scl_s_q;
  reg        sda_m_q;
  reg        sda_s_q;
  reg [31:0] low_cnt_q;
  wire       bus_high;

  // Two-stage synchronisers; only the second stage is read by logic.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_m_q <= 1'b0;
      scl_s_q <= 1'b0;
      sda_m_q <= 1'b0;
      sda_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_pin;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_pin;
      sda_s_q <= sda_m_q;
    end
  end

  assign bus_high = scl_s_q | sda_s_q;

  // Mode machine: a high on either line wakes at once, and only an unbroken
  // low on both lines lasting the whole timeout puts the gauge to sleep.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q  <= 1'b1;
      low_cnt_q <= 32'h0000_0000;
    end else if (bus_high) begin
      active_q  <= 1'b1;
      low_cnt_q <= 32'h0000_0000;
    end else if (!sleep_enable || !active_q) begin
      low_cnt_q <= 32'h0000_0000;
    end else if (low_cnt_q == TIMEOUT - 1) begin
      active_q  <= 1'b0;
      low_cnt_q <= 32'h0000_0000;
    end else begin
      low_cnt_q <= low_cnt_q + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

/* hw/gpm_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "gpm_consts.vh"

module gpm_top #(
  parameter integer TIMEOUT_CYC = `GPM_TIMEOUT_CYC,
  parameter integer CONV_CYC    = `GPM_CONV_CYC,
  parameter integer ACC_W       = 32
) (
  input  wire                clk,
  input  wire                arst_n,
  input  wire                scl_pin,
  input  wire                sda_pin,
  input  wire                cfg_sleep_enable,
  input  wire                cfg_internal_temp_select,
  input  wire                cfg_wr_en,
  input  wire                cfg_sleep_enable_wr,
  input  wire                cfg_temp_select_wr,
  input  wire [7:0]          nv_scale_factor,
  input  wire                scale_wr_en,
  input  wire [7:0]          scale_wr_data,
  input  wire                acc_wr_en,
  input  wire [ACC_W-1:0]    acc_wr_data,
  input  wire signed [15:0]  adc_current_raw,
  input  wire [12:0]         adc_voltage_raw,
  input  wire signed [11:0]  adc_aux_raw,
  input  wire signed [10:0]  adc_temp_raw,
  output reg                 active_q,
  output reg                 conv_done_q,
  output reg                 offset_cycle_q,
  output reg                 vout_enable_q,
  output reg                 sleep_enable_q,
  output reg                 internal_temp_select_q,
  output reg  [7:0]          scale_factor_q,
  output reg  [15:0]         current_q,
  output reg  [15:0]         voltage_q,
  output reg  [15:0]         aux_input_zero_q,
  output reg  [15:0]         aux_input_one_q,
  output reg  [15:0]         temperature_q,
  output reg  [ACC_W-1:0]    accumulator_q,
  output reg  [ACC_W+7:0]    weighted_charge_q
);

  wire                      active_w;
  wire                      tick;
  reg                       cfg_loaded_q;
  reg                       aux_sel_q;
  reg  [`GPM_OFS_CNT_W-1:0] conv_cnt_q;
  reg  signed [15:0]        offset_q;
  reg  [15:0]               cur_d;
  reg  [ACC_W-1:0]          acc_d;
  wire                      ofs_slot;
  wire                      temp_slot;

  // Saturating 16-bit signed subtraction, used for offset correction.
  function [15:0] sat_sub;
    input signed [15:0] a;
    input signed [15:0] b;
    reg   signed [16:0] diff;
    begin
      diff = {a[15], a} - {b[15], b};
      if (diff[16] != diff[15]) begin
        sat_sub = diff[16] ? `GPM_NEG_MIN : `GPM_POS_MAX;
      end else begin
        sat_sub = diff[15:0];
      end
    end
  endfunction

  // Sign-extends a 16-bit result to the accumulator width.
  function [ACC_W-1:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{(ACC_W-16){v[15]}}, v};
    end
  endfunction

  // Mode control sits on the synchronised bus lines; the active level it
  // drives gates the conversion timebase and the reference enable below.
  gpm_sleep_ctrl #(
    .TIMEOUT (TIMEOUT_CYC)
  ) u_sleep (
    .clk          (clk),
    .arst_n       (arst_n),
    .scl_pin      (scl_pin),
    .sda_pin      (sda_pin),
    .sleep_enable (sleep_enable_q),
    .active_q     (active_w)
  );

  // The conversion timebase runs only in Active, so Sleep cannot start a
  // conversion.
  gpm_tick #(
    .PERIOD (CONV_CYC)
  ) u_tick (
    .clk     (clk),
    .arst_n  (arst_n),
    .enable  (active_w),
    .tick_q  (tick)
  );

  assign ofs_slot  = (conv_cnt_q == `GPM_OFS_EVERY - 1);
  assign temp_slot = aux_sel_q & internal_temp_select_q;

  // Configuration and the scale-factor shadow. The shadow is loaded from
  // nonvolatile storage once after reset release; host writes go through in
  // either mode, since nothing here looks at the power mode.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_loaded_q           <= 1'b0;
      scale_factor_q         <= `GPM_SCALE_RST;
      sleep_enable_q         <= 1'b0;
      internal_temp_select_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      cfg_loaded_q           <= 1'b1;
      scale_factor_q         <= nv_scale_factor;
      sleep_enable_q         <= cfg_sleep_enable;
      internal_temp_select_q <= cfg_internal_temp_select;
    end else begin
      if (scale_wr_en) begin
        scale_factor_q <= scale_wr_data;
      end
      if (cfg_wr_en) begin
        sleep_enable_q         <= cfg_sleep_enable_wr;
        internal_temp_select_q <= cfg_temp_select_wr;
      end
    end
  end

  // Conversion sequencing: counts conversions to find the offset slot and
  // alternates the auxiliary channel on each non-offset conversion.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_q     <= {`GPM_OFS_CNT_W{1'b0}};
      aux_sel_q      <= 1'b0;
      offset_q       <= 16'sh0000;
      conv_done_q    <= 1'b0;
      offset_cycle_q <= 1'b0;
    end else begin
      conv_done_q    <= tick & ~ofs_slot;
      offset_cycle_q <= tick & ofs_slot;
      if (tick) begin
        conv_cnt_q <= conv_cnt_q + {{(`GPM_OFS_CNT_W-1){1'b0}}, 1'b1};
        if (ofs_slot) begin
          offset_q <= adc_current_raw;
        end else begin
          aux_sel_q <= ~aux_sel_q;
        end
      end
    end
  end

  // Combinational next values of the current result and accumulator.
  always @* begin
    cur_d = sat_sub(adc_current_raw, offset_q);
    acc_d = accumulator_q + sext16(cur_d);
  end

  // Result registers. They change on a non-offset conversion tick, which never fires in
  // Sleep, and the accumulator also on a host write, which goes through in either mode and beats a same-cycle tick, so no other result changes then.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      current_q        <= `GPM_RES_RST;
      voltage_q        <= `GPM_RES_RST;
      aux_input_zero_q <= `GPM_RES_RST;
      aux_input_one_q  <= `GPM_RES_RST;
      temperature_q    <= `GPM_RES_RST;
      accumulator_q    <= `GPM_ACC_RST;
    end else if (acc_wr_en) begin
      accumulator_q <= acc_wr_data;
    end else if (tick && !ofs_slot) begin
      current_q     <= cur_d;
      accumulator_q <= acc_d;
      if (adc_voltage_raw > `GPM_VOLT_MAX_RAW) begin
        voltage_q <= `GPM_POS_MAX;
      end else begin
        voltage_q <= {1'b0, adc_voltage_raw[11:0], {`GPM_VOLT_SHIFT{1'b0}}};
      end
      if (!aux_sel_q) begin
        aux_input_zero_q <= {adc_aux_raw, {`GPM_AUX_PAD{1'b0}}};
      end else if (temp_slot) begin
        temperature_q <= {adc_temp_raw, {`GPM_TEMP_PAD{1'b0}}};
      end else begin
        aux_input_one_q <= {adc_aux_raw, {`GPM_AUX_PAD{1'b0}}};
      end
    end
  end

  // Mode, reference enable and capacity weighting. The reference output is
  // left off in the temperature slot because no divider is being measured.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_q          <= 1'b1;
      vout_enable_q     <= 1'b0;
      weighted_charge_q <= {(ACC_W+8){1'b0}};
    end else begin
      active_q          <= active_w;
      vout_enable_q     <= active_w & ~temp_slot & ~ofs_slot;
      weighted_charge_q <= $signed(accumulator_q) * $signed({1'b0, scale_factor_q});
    end
  end

endmodule
`default_nettype wire

/* verification/gpm_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module gpm_top_checker #(
  parameter int TIMEOUT_CYC = 50,
  parameter int ACC_W       = 32
) (
  input wire logic             clk,
  input wire logic             arst_n,
  input wire logic             scl_pin,
  input wire logic             sda_pin,
  input wire logic             acc_wr_en,
  input wire logic             scale_wr_en,
  input wire logic [7:0]       scale_wr_data,
  input wire logic [12:0]      adc_voltage_raw,
  input wire logic             active_q,
  input wire logic             conv_done_q,
  input wire logic             offset_cycle_q,
  input wire logic             sleep_enable_q,
  input wire logic [7:0]       scale_factor_q,
  input wire logic [15:0]      current_q,
  input wire logic [15:0]      voltage_q,
  input wire logic [ACC_W-1:0] accumulator_q
);
  int unsigned low_cnt_q;

  // Unbroken cycles with both pins low; saturates so it cannot wrap.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) low_cnt_q <= 0;
    else if (scl_pin || sda_pin) low_cnt_q <= 0;
    else if (low_cnt_q < 1000) low_cnt_q <= low_cnt_q + 1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_pins_high;
    (scl_pin || sda_pin) [*6];
  endsequence
  sequence s_asleep;
    (!active_q) [*2];
  endsequence

  a_wake_fast: assert property (s_pins_high |-> active_q)
    else $error("gauge did not wake with a bus line high");
  a_sleep_gated: assert property ($fell(active_q) |-> $past(sleep_enable_q))
    else $error("gauge slept with sleep disabled");
  a_sleep_early: assert property ($fell(active_q) |-> low_cnt_q >= TIMEOUT_CYC)
    else $error("gauge slept before the bus-low timeout");
  a_sleep_late: assert property (sleep_enable_q && low_cnt_q == TIMEOUT_CYC + 8 |-> !active_q)
    else $error("gauge stayed active past the bus-low timeout");
  a_asleep_quiet: assert property (s_asleep |-> !conv_done_q && !offset_cycle_q)
    else $error("conversion seen while asleep");
  a_results_hold: assert property (s_asleep |-> $stable(current_q) && $stable(voltage_q)
    && ($stable(accumulator_q) || $past(acc_wr_en)))
    else $error("result changed while asleep");
  a_acc_adds: assert property (conv_done_q && !$past(acc_wr_en) |-> accumulator_q ==
    $past(accumulator_q) + {{(ACC_W-16){current_q[15]}}, current_q})
    else $error("accumulator did not add the current result");
  a_volt_form: assert property (conv_done_q && !$past(acc_wr_en) |-> voltage_q ==
    ($past(adc_voltage_raw) > 13'h0fff ? 16'h7fff : {$past(adc_voltage_raw), 3'b000}))
    else $error("voltage result badly formed");
  a_scale_load: assert property ($past(scale_wr_en) |-> scale_factor_q == $past(scale_wr_data))
    else $error("scale shadow not overwritten");
  a_offset_quiet: assert property (offset_cycle_q |-> !conv_done_q && $stable(current_q))
    else $error("offset slot changed the current result");
endmodule

bind gpm_top gpm_top_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .ACC_W(ACC_W)) u_chk (.clk, .arst_n,
  .scl_pin, .sda_pin, .acc_wr_en, .scale_wr_en, .scale_wr_data, .adc_voltage_raw, .active_q,
  .conv_done_q, .offset_cycle_q, .sleep_enable_q, .scale_factor_q, .current_q, .voltage_q,
  .accumulator_q);
`default_nettype wire

/* verification/gpm_bus_host.sv */
`timescale 1ns/1ps
`default_nettype none
module gpm_bus_host (
  output var logic scl,
  output var logic sda
);
  // Released lines fall to the pull-down level; the clock stands still between frames.
  initial begin
    scl = 1'b0;
    sda = 1'b0;
  end

  // Pulled-up idle bus, or a fully released one.
  task automatic hold(input logic lvl);
    scl = lvl;
    sda = lvl;
  endtask

  // One transfer at 800 ns a bit; no low phase lasts long enough to look like sleep.
  task automatic frame(input int bits);
    #37;
    scl = 1'b1;
    sda = 1'b1;
    #400;
    sda = 1'b0;
    for (int i = 0; i < bits; i++) begin
      #400;
      scl = 1'b0;
      #200;
      sda = i[0];
      #200;
      scl = 1'b1;
    end
    #400;
    scl = 1'b0;
    sda = 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TO = 50;
  localparam int CV = 20;
  typedef struct packed {
    logic [15:0] cur;
    logic [12:0] vlt;
    logic [11:0] aux;
    logic [15:0] ev;
  } gpm_row_t;
  gpm_row_t    rows [4] = '{'{16'h0040, 13'h0abc, 12'h123, 16'h55e0},
    '{16'hfff0, 13'h1000, 12'h800, 16'h7fff}, '{16'h7fff, 13'h0fff, 12'h7ff, 16'h7ff8},
    '{16'h8000, 13'h0000, 12'h001, 16'h0000}};
  logic        clk, arst_n, scl, sda, cfg_wr, sl_wr, ts_wr, sc_en, ac_en, act, cd, oc, se, ts;
  logic        cfg_se, cfg_ts, vout;
  logic [7:0]  sc_dat, scale, nv_sf;
  logic [10:0] temp_raw;
  logic [11:0] aux_raw;
  logic [12:0] vlt_raw;
  logic [15:0] cur_raw, cur, vlt, ax0, ax1, tmp;
  logic [31:0] ac_dat, acc, accum;
  logic [39:0] wgt;
  int          checked, err_total, n;

  gpm_bus_host host (.scl(scl), .sda(sda));
  gpm_top #(.TIMEOUT_CYC(TO), .CONV_CYC(CV), .ACC_W(32)) uut (.clk(clk), .arst_n(arst_n),
    .scl_pin(scl), .sda_pin(sda), .cfg_sleep_enable(cfg_se), .cfg_internal_temp_select(cfg_ts),
    .cfg_wr_en(cfg_wr), .cfg_sleep_enable_wr(sl_wr), .cfg_temp_select_wr(ts_wr),
    .nv_scale_factor(nv_sf), .scale_wr_en(sc_en), .scale_wr_data(sc_dat), .acc_wr_en(ac_en),
    .acc_wr_data(ac_dat), .adc_current_raw(cur_raw), .adc_voltage_raw(vlt_raw),
    .adc_aux_raw(aux_raw), .adc_temp_raw(temp_raw), .active_q(act), .conv_done_q(cd),
    .offset_cycle_q(oc), .vout_enable_q(vout), .sleep_enable_q(se), .internal_temp_select_q(ts),
    .scale_factor_q(scale), .current_q(cur), .voltage_q(vlt), .aux_input_zero_q(ax0),
    .aux_input_one_q(ax1), .temperature_q(tmp), .accumulator_q(accum),
    .weighted_charge_q(wgt));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a design flag; n returns the cycles spent, a timeout ends the run.
  task automatic wait_for(input int k, input int lim);
    n = 0;
    while ((k == 0 ? cd : k == 1 ? oc : k == 2 ? !act : act) !== 1'b1) begin
      if (n == lim) begin
        err_total++;
        test_done();
      end
      step(1);
      n++;
    end
    step(1);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {arst_n, cfg_wr, sl_wr, ts_wr, sc_en, ac_en, sc_dat, ac_dat} = '0;
    {cfg_se, cfg_ts, nv_sf} = {2'b00, 8'h5a};
    {cur_raw, vlt_raw, aux_raw, temp_raw} = '0;
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    step(2);
    chk("scale_load", scale, 8'h5a);
    acc = '0;
    // Table rows: sign, saturation and field placement, aux slots alternating.
    for (int i = 0; i < 4; i++) begin
      {cur_raw, vlt_raw, aux_raw} = {rows[i].cur, rows[i].vlt, rows[i].aux};
      wait_for(0, CV + 5);
      acc += {{16{cur_raw[15]}}, cur_raw};
      chk("current", cur, rows[i].cur);
      chk("voltage", vlt, rows[i].ev);
      chk("aux", i[0] ? ax1 : ax0, {rows[i].aux, 4'h0});
      chk("accum", accum, acc);
    end
    chk("no_sleep", act, 1'b1);
    $display("test rows done");
    // Config and shadow writes, then the temperature slot.
    host.hold(1'b1);
    {cfg_wr, sl_wr, ts_wr, sc_en, sc_dat, temp_raw, aux_raw} = {4'hf, 8'h03, 11'h7f9, 12'h555};
    step(1);
    {cfg_wr, sc_en} = '0;
    chk("temp_sel", ts, 1'b1);
    chk("scale_wr", scale, 8'h03);
    wait_for(0, CV + 5);
    chk("vout_temp", vout, 1'b0);
    wait_for(0, CV + 5);
    acc += 32'hffff_0000;
    chk("temp", tmp, 16'hff20);
    chk("aux1_kept", ax1, 16'h0010);
    chk("vout_aux", vout, 1'b1);
    chk("weighted", wgt, $signed(acc) * 40'sd3);
    $display("test config done");
    // A long transfer keeps the gauge awake; release then times out into sleep.
    cur_raw = '0;
    host.frame(24);
    chk("frame_awake", act, 1'b1);
    wait_for(2, TO + 20);
    chk("sleep_time", n >= TO && n <= TO + 8, 1'b1);
    cur_raw = 16'h0111;
    step(3 * CV);
    chk("sleep_cur", cur, 16'h0000);
    chk("sleep_vout", vout, 1'b0);
    chk("sleep_acc", accum, acc);
    {ac_en, ac_dat} = {1'b1, 32'h0000_0100};
    step(1);
    ac_en = 1'b0;
    chk("acc_wr", accum, 32'h0000_0100);
    $display("test sleep done");
    host.hold(1'b1);
    wait_for(3, 6);
    wait_for(0, CV + 8);
    chk("resume", accum, 32'h0000_0211);
    cur_raw = 16'h0020;
    wait_for(0, CV + 2);
    chk("period", n, CV - 1);
    wait_for(1, 22000);
    wait_for(0, CV + 2);
    chk("offset", cur, 16'h0000);
    $display("test offset done");
    // Mid-run reset clears results and settings and sets active; the release then reloads the strapped settings.
    arst_n = 1'b0;
    step(1);
    chk("rst", {act, se, scale, cur, accum[13:0]}, 40'h80_0000_0000);
    {cfg_se, cfg_ts, nv_sf} = {2'b11, 8'h33};
    arst_n = 1'b1;
    step(2);
    chk("reload", {act, se, ts, scale}, 11'h733);
    $display("test reset done");
    test_done();
  end
endmodule
`default_nettype wire
